// ===== design/tlpr_seq.sv
// Tri-level two-phase drive sequencer with boot refresh and tri-state timeout.
//
// Notes on behaviour
// - Outputs: high, low, or mid-off.
// - Any fault drives outputs to mid.
// - Thirty-two mid-to-low refresh pulses before soft-start.
// - Refresh at switching rate, minimum on-time wide.
// - Mid level starts a 60 us timeout.
// - Timeout expiry sends four more refresh pulses.
// - Peak current ends the high pulse.
// - Each phase has its own comparator.
// - Pulse skipped entirely if its comparator is already tripped at period start.
// - Each phase at half oscillator rate, opposed.
// - Secondary overcurrent: mid outputs, request hiccup.
// - Phase tied to supply disables it.
`timescale 1ns/1ps
`default_nettype none
module tlpr_seq
	import tlpr_pkg::*;
#(
	parameter int TMO_CYCLES = TMO_CYC,
	parameter int MIN_ON = MIN_ON_CYC
)
(
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST,
	// Oscillator and start-up control.
	input wire logic OSC_CLK_IN,
	input wire logic SOFT_START_GO,
	// Fault inputs.
	input wire logic FAULT_REQ,
	input wire logic SEC_OVERCURRENT,
	// Peak-current comparator results, one per phase.
	input wire logic [1:0] PEAK_CMP_HIT,
	// Phase pins sensed as tied to the supply rail.
	input wire logic [1:0] PHASE_TIED_HIGH,
	// Drive outputs and status.
	output logic [1:0] PHASE_ONE_DRIVE_OUT,
	output logic [1:0] PHASE_TWO_DRIVE_OUT,
	output logic HICCUP_REQ,
	output logic BOOT_DONE
);
	localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_CYCLES);
	localparam logic [TMO_W-1:0] TMO_ONE = TMO_W'(1);
	localparam logic [TMO_W-1:0] TMO_ZERO = TMO_W'(0);

	// Pins are asynchronous; only the second stage is ever read.
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			sync_a <= '0;
			sync_b <= '0;
		end
		else
		begin
			sync_a <= {PHASE_TIED_HIGH, PEAK_CMP_HIT, SEC_OVERCURRENT, FAULT_REQ, SOFT_START_GO, OSC_CLK_IN};
			sync_b <= sync_a;
		end
	end

	wire osc_s = sync_b[0];
	wire ss_s = sync_b[1];
	wire flt_s = sync_b[2];
	wire soc_s = sync_b[3];
	wire [1:0] cmp_s = sync_b[5:4];
	wire [1:0] tied_s = sync_b[7:6];
	wire fault_any = flt_s || soc_s;

	// Oscillator edges alternate between the phases, so each runs at half rate, 180 degrees apart.
	logic osc_prev;
	logic slot;
	wire osc_tick = osc_s && !osc_prev;
	wire [1:0] phase_start = {osc_tick && slot, osc_tick && !slot};

	tlpr_state_type state;
	tlpr_state_type next_state;
	logic [5:0] pulses_left;
	logic [5:0] next_pulses;
	logic refresh_go;
	logic next_go;
	logic [TMO_W-1:0] tmo_cnt;

	wire tmo_done = (tmo_cnt == TMO_LAST);

	always_comb
	begin
		next_state = state;
		next_pulses = pulses_left;
		next_go = refresh_go;
		case (state)
			ST_BOOT, ST_REFRESH:
			begin
				if (phase_start[0])
				begin
					if (pulses_left == PULSE_ZERO)
					begin
						next_go = 1'b0;
						next_state = ST_WAIT;
					end
					else
					begin
						next_go = 1'b1;
						next_pulses = pulses_left - PULSE_ONE;
					end
				end
			end
			ST_WAIT:
			begin
				if (ss_s)
					next_state = ST_RUN;
				else if (tmo_done)
				begin
					next_state = ST_REFRESH;
					next_pulses = TMO_PULSES;
					next_go = 1'b0;
				end
			end
			ST_RUN:
			begin
				if (!ss_s)
					next_state = ST_WAIT;
			end
			ST_FAULT:
			begin
				if (!fault_any)
					next_state = ST_WAIT;
			end
			default:
			begin
				next_state = ST_FAULT;
			end
		endcase
		if (fault_any)
		begin
			next_state = ST_FAULT;
			next_go = 1'b0;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state <= ST_BOOT;
			pulses_left <= BOOT_PULSES;
			refresh_go <= 1'b0;
			osc_prev <= 1'b0;
			slot <= 1'b0;
			HICCUP_REQ <= 1'b0;
			BOOT_DONE <= 1'b0;
		end
		else
		begin
			state <= next_state;
			pulses_left <= next_pulses;
			refresh_go <= next_go;
			osc_prev <= osc_s;
			slot <= slot ^ osc_tick;
			HICCUP_REQ <= soc_s || flt_s;
			BOOT_DONE <= BOOT_DONE || (state == ST_BOOT && next_state == ST_WAIT);
		end
	end

	// The timer lives only while resting at mid; any other state clears it, which re-arms it.
	always_ff @(posedge CLK)
	begin
		if (RST)
			tmo_cnt <= TMO_ZERO;
		else if (state != ST_WAIT)
			tmo_cnt <= TMO_ZERO;
		else if (!tmo_done)
			tmo_cnt <= tmo_cnt + TMO_ONE;
	end

	// The next value is used so the closing tick, which only ends the burst, cannot launch one pulse too many.
	wire refreshing = (state == ST_BOOT || state == ST_REFRESH) && next_go;
	logic [1:0] mode [NPHASE];
	logic [1:0] level [NPHASE];

	genvar gi;
	generate
		for (gi = 0; gi < NPHASE; gi++)
		begin : g_phase
			// A phase tied to the rail is unused and stays at mid.
			assign mode[gi] = (fault_any || tied_s[gi]) ? MODE_MID :
				(state == ST_RUN) ? MODE_RUN :
				refreshing ? MODE_REFRESH : MODE_MID;
			tlpr_phase #(.MIN_ON(MIN_ON)) u_phase
			(
				.clk(CLK),
				.rst(RST),
				.period_start(phase_start[gi]),
				.mode(mode[gi]),
				.cmp_hit(cmp_s[gi]),
				.level_out(level[gi])
			);
		end
	endgenerate

	assign PHASE_ONE_DRIVE_OUT = level[0];
	assign PHASE_TWO_DRIVE_OUT = level[1];

	// Helper: mid-to-low transitions on phase one during the boot burst.
	logic [6:0] boot_seen;
	always_ff @(posedge CLK)
	begin
		if (RST)
			boot_seen <= 7'h00;
		else if (state == ST_BOOT && level[0] == LVL_LOW && $past(level[0]) == LVL_MID)
			boot_seen <= boot_seen + 7'h01;
	end

	chk_fault_mid: assert property (@(posedge CLK) disable iff (RST)
		fault_any |=> (level[0] == LVL_MID && level[1] == LVL_MID))
		else $error("fault did not force mid level");
	chk_overcurrent_hiccup: assert property (@(posedge CLK) disable iff (RST)
		soc_s |=> (HICCUP_REQ && state == ST_FAULT))
		else $error("overcurrent did not request hiccup");
	chk_boot_count: assert property (@(posedge CLK) disable iff (RST)
		(state == ST_BOOT && next_state == ST_WAIT && !tied_s[0] && !$past(tied_s[0]))
		|-> boot_seen == 7'h20)
		else $error("boot burst is not thirty-two pulses");
	chk_timeout_refresh: assert property (@(posedge CLK) disable iff (RST)
		(state == ST_WAIT && tmo_done && !ss_s && !fault_any)
		|=> (state == ST_REFRESH && pulses_left == TMO_PULSES))
		else $error("timeout did not start four refresh pulses");
	chk_timeout_length: assert property (@(posedge CLK) disable iff (RST)
		$rose(state == ST_WAIT) |-> (tmo_cnt == TMO_ZERO) ##1 (tmo_cnt == TMO_ONE || state != ST_WAIT))
		else $error("tri-state timer not started on mid entry");
	chk_high_cancels: assert property (@(posedge CLK) disable iff (RST)
		(level[0] == LVL_HIGH || level[1] == LVL_HIGH) |-> tmo_cnt == TMO_ZERO)
		else $error("timeout running during a high command");
	chk_rest_mid: assert property (@(posedge CLK) disable iff (RST)
		(state == ST_WAIT && $past(state) == ST_WAIT) |=> (level[0] != LVL_HIGH && level[1] != LVL_HIGH))
		else $error("high level before soft-start");
	// Helper: high when phase one took the latest oscillator tick; low before the first tick.
	logic last_one;
	always_ff @(posedge CLK)
	begin
		if (RST)
			last_one <= 1'b0;
		else if (osc_tick)
			last_one <= phase_start[0];
	end

	chk_phase_offset: assert property (@(posedge CLK) disable iff (RST)
		osc_tick |-> (phase_start[0] == !last_one && phase_start[1] == last_one))
		else $error("phase starts do not alternate");
	chk_tied_mid: assert property (@(posedge CLK) disable iff (RST)
		(tied_s[0] |=> level[0] == LVL_MID) and (tied_s[1] |=> level[1] == LVL_MID))
		else $error("tied phase is driven");
endmodule // tlpr_seq
`default_nettype wire

// ===== design/tlpr_pkg.sv
// Shared constants and types for the tri-level phase drive sequencer.
package tlpr_pkg;
	localparam int CLK_MHZ = 200;
	// Minimum high/refresh pulse time in ns.
	localparam int MIN_ON_NS = 100;
	localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
	// Tri-state timeout, nominal 60 us; the analog original spreads by about 60 percent either way.
	localparam int TMO_NS = 60000;
	localparam int TMO_CYC = (TMO_NS * CLK_MHZ) / 1000;
	localparam int TMO_W = 16;
	localparam logic [5:0] BOOT_PULSES = 6'h20;
	localparam logic [5:0] TMO_PULSES = 6'h04;
	localparam logic [5:0] PULSE_ZERO = 6'h00;
	localparam logic [5:0] PULSE_ONE = 6'h01;
	// Drive level codes on each phase output.
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;
	localparam logic [1:0] LVL_BAD = 2'h3;
	// Per-phase operating modes.
	localparam logic [1:0] MODE_MID = 2'h0;
	localparam logic [1:0] MODE_REFRESH = 2'h1;
	localparam logic [1:0] MODE_RUN = 2'h2;
	localparam int NPHASE = 2;
	localparam int SYNC_W = 8;
	typedef enum logic [4:0]
	{
		ST_BOOT = 5'h01,
		ST_REFRESH = 5'h02,
		ST_WAIT = 5'h04,
		ST_RUN = 5'h08,
		ST_FAULT = 5'h10
	} tlpr_state_type;
endpackage

// ===== design/tlpr_phase.sv
// One phase drive engine: refresh pulses, peak-current high pulses and pulse skipping.
`timescale 1ns/1ps
`default_nettype none
module tlpr_phase
	import tlpr_pkg::*;
#(
	parameter int MIN_ON = MIN_ON_CYC
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Control from the sequencer.
	input wire logic period_start,
	input wire logic [1:0] mode,
	input wire logic cmp_hit,
	// Drive level.
	output logic [1:0] level_out
);
	localparam int W = $clog2(MIN_ON + 2);
	localparam logic [W-1:0] WIDTH_ONE = W'(1);
	localparam logic [W-1:0] WIDTH_MIN = W'(MIN_ON);
	localparam logic [W-1:0] WIDTH_MAX = W'(MIN_ON + 1);

	logic [W-1:0] width;
	logic [1:0] next_level;
	logic [W-1:0] next_width;

	wire fire_refresh = period_start && (mode == MODE_REFRESH);
	wire fire_run = period_start && (mode == MODE_RUN) && !cmp_hit;
	wire skip_pulse = period_start && (mode == MODE_RUN) && cmp_hit;
	wire refresh_end = (level_out == LVL_LOW) && (mode == MODE_REFRESH) && (width == WIDTH_MIN);
	// Blanking to the minimum width keeps switching noise from ending a pulse early.
	wire high_end = (level_out == LVL_HIGH) && cmp_hit && (width >= WIDTH_MIN);

	always_comb
	begin
		if (mode == MODE_MID)
			next_level = LVL_MID;
		else if (fire_refresh || skip_pulse)
			next_level = LVL_LOW;
		else if (fire_run)
			next_level = LVL_HIGH;
		else if (refresh_end)
			next_level = LVL_MID;
		else if (high_end)
			next_level = LVL_LOW;
		else
			next_level = level_out;
	end

	assign next_width = (next_level != level_out || fire_refresh) ? WIDTH_ONE :
		((width == WIDTH_MAX) ? width : width + WIDTH_ONE);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			level_out <= LVL_MID;
			width <= WIDTH_ONE;
		end
		else
		begin
			level_out <= next_level;
			width <= next_width;
		end
	end

	logic [W-1:0] low_len;
	always_ff @(posedge clk)
	begin
		if (rst)
			low_len <= WIDTH_ONE;
		else if (level_out != LVL_LOW)
			low_len <= WIDTH_ONE;
		else if (low_len != WIDTH_MAX)
			low_len <= low_len + WIDTH_ONE;
	end

	chk_refresh_width: assert property (@(posedge clk) disable iff (rst)
		($fell(level_out == LVL_LOW) && $past(mode) == MODE_REFRESH && mode == MODE_REFRESH)
		|-> $past(low_len) == WIDTH_MIN)
		else $error("refresh pulse width is not the minimum on-time");
	chk_peak_end: assert property (@(posedge clk) disable iff (rst)
		(level_out == LVL_HIGH && cmp_hit && width >= WIDTH_MIN && mode == MODE_RUN && !period_start)
		|=> level_out == LVL_LOW)
		else $error("high pulse not ended by peak current");
	chk_skip_pulse: assert property (@(posedge clk) disable iff (rst)
		skip_pulse |=> level_out == LVL_LOW)
		else $error("pulse not skipped");
	chk_level_code: assert property (@(posedge clk) disable iff (rst)
		level_out != LVL_BAD)
		else $error("illegal drive level code");
endmodule // tlpr_phase
`default_nettype wire

// ===== dv/tlpr_drv_model.sv
// Tri-level gate driver stand-in that tallies pulses and widths on both phases.
`timescale 1ns/1ps
`default_nettype none
module tlpr_drv_model
	import tlpr_pkg::*;
(
	// Clock and phase drives.
	input wire logic clk,
	input wire logic [1:0] lvl_one,
	input wire logic [1:0] lvl_two
);
	int low_cnt[2];
	int high_cnt[2];
	int low_w[2];
	int high_w[2];
	int run[2];
	int bad;
	time low_t[2];
	logic [1:0] prv[2] = '{LVL_MID, LVL_MID};
	logic [1:0] cur[2];
	// Mid means both switches off, so only entries into low and high are tallied.
	always @(posedge clk)
	begin
		cur = '{lvl_one, lvl_two};
		for (int i = 0; i < 2; i++)
		begin
			bad += (cur[i] === LVL_BAD);
			if (cur[i] === prv[i])
				run[i]++;
			else
			begin
				if (prv[i] === LVL_LOW)
					low_w[i] = run[i];
				if (prv[i] === LVL_HIGH)
					high_w[i] = run[i];
				run[i] = 1;
				low_cnt[i] += (cur[i] === LVL_LOW);
				low_t[i] = (cur[i] === LVL_LOW) ? $time : low_t[i];
				high_cnt[i] += (cur[i] === LVL_HIGH);
			end
			prv[i] = cur[i];
		end
	end
endmodule // tlpr_drv_model
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the tri-level phase drive sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import tlpr_pkg::*;
;
	localparam int TMO = 400;
	localparam int HALF = 40;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic osc = 1'b0;
	logic osc_en = 1'b0;
	logic go = 1'b0;
	logic flt = 1'b0;
	logic soc = 1'b0;
	logic [1:0] cmp = 2'h0;
	logic [1:0] tied = 2'h0;
	logic [1:0] d1;
	logic [1:0] d2;
	logic hic;
	logic bdone;
	int oc;
	int cyc;
	int errors;
	int checks_done;
	int seed = 89;
	int n[2];
	int d;
	int k;
	tlpr_seq #(.TMO_CYCLES(TMO), .MIN_ON(MIN_ON_CYC)) dut_u (.CLK(clk), .RST(rst), .OSC_CLK_IN(osc),
		.SOFT_START_GO(go), .FAULT_REQ(flt), .SEC_OVERCURRENT(soc), .PEAK_CMP_HIT(cmp),
		.PHASE_TIED_HIGH(tied), .PHASE_ONE_DRIVE_OUT(d1), .PHASE_TWO_DRIVE_OUT(d2),
		.HICCUP_REQ(hic), .BOOT_DONE(bdone));
	tlpr_drv_model drv_u (.clk(clk), .lvl_one(d1), .lvl_two(d2));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	// The oscillator can be stopped so the timeout expires with no tick to arm the refresh.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (osc_en)
		begin
			oc <= (oc == HALF - 1) ? 0 : oc + 1;
			osc <= (oc == HALF - 1) ? ~osc : osc;
		end
		if (cyc == 30000)
		begin
			errors++;
			give_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks_done %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Pulse ends two synchroniser stages plus one register after the comparator rises.
	function automatic logic win(input int w, input int dd);
		return w >= dd + 2 && w <= dd + 4;
	endfunction
	task automatic wait_hi(input logic want);
		int j;
		j = 0;
		do
		begin
			@(negedge clk);
			j++;
		end
		while ((d1 === LVL_HIGH) !== want && j < 400);
	endtask
	task automatic boot(input logic [1:0] t);
		int h;
		@(posedge clk);
		rst <= 1'b1;
		tied <= t;
		osc_en <= 1'b0;
		go <= 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		osc_en <= 1'b1;
		@(negedge clk);
		check(d1, LVL_MID);
		check(bdone, 1'b0);
		n = drv_u.low_cnt;
		h = drv_u.high_cnt[0] + drv_u.high_cnt[1];
		k = 0;
		while (bdone !== 1'b1 && k < 6000)
		begin
			@(negedge clk);
			k++;
		end
		check(drv_u.low_cnt[0] - n[0], t[0] ? 0 : 32);
		check(drv_u.low_cnt[1] - n[1], t[1] ? 0 : 32);
		check(drv_u.high_cnt[0] + drv_u.high_cnt[1] - h, 0);
		check(drv_u.low_w[t[0]], MIN_ON_CYC);
		check(d2, LVL_MID);
		$display("boot burst done, tied %b", t);
	endtask
	initial
	begin
		boot(2'h0);
		check(drv_u.low_t[1] - drv_u.low_t[0], 2 * HALF * 5);
		repeat (300) @(negedge clk);
		check(drv_u.low_cnt[0] - n[0], 32);
		@(posedge clk);
		osc_en <= 1'b0;
		repeat (300) @(posedge clk);
		n = drv_u.low_cnt;
		osc_en <= 1'b1;
		repeat (960) @(negedge clk);
		check(drv_u.low_cnt[0] - n[0], 4);
		check(drv_u.low_cnt[1] - n[1], 4);
		$display("timeout refresh done");
		@(posedge clk);
		go <= 1'b1;
		cmp <= 2'h2;
		k = drv_u.high_cnt[1];
		for (int i = 0; i < 8; i++)
		begin
			d = MIN_ON_CYC + ($unsigned($random(seed)) % 40);
			wait_hi(1'b1);
			repeat (d) @(posedge clk);
			cmp[0] <= 1'b1;
			wait_hi(1'b0);
			@(posedge clk);
			cmp[0] <= 1'b0;
			@(negedge clk);
			check(win(drv_u.high_w[0], d), 1'b1);
		end
		check(drv_u.high_cnt[1] - k, 0);
		$display("peak current run done");
		for (int f = 0; f < 2; f++)
		begin
			@(posedge clk);
			{soc, flt} <= f ? 2'h2 : 2'h1;
			repeat (4) @(negedge clk);
			check(d1, LVL_MID);
			check(d2, LVL_MID);
			check(hic, 1'b1);
			@(posedge clk);
			{soc, flt} <= 2'h0;
			repeat (6) @(negedge clk);
			check(hic, 1'b0);
		end
		$display("fault handling done");
		boot(2'h2);
		boot(2'h1);
		check(drv_u.bad, 0);
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
